//--- inc/gauge_panel_defs.svh
`ifndef GAUGE_PANEL_DEFS_SVH
`define GAUGE_PANEL_DEFS_SVH

// Clock rate and the one-eighth-second tick.
`define CLK_HZ            100000000
`define TICK_MS           125
`define TICK_CYCLES       ((`CLK_HZ / 1000) * `TICK_MS)
// Button hold time and power-up self-check time, in milliseconds.
`define ZERO_HOLD_MS      3000
`define SELF_CHECK_MS     500
`define ZERO_HOLD_TICKS   (`ZERO_HOLD_MS / `TICK_MS)
`define SELF_CHECK_TICKS  (`SELF_CHECK_MS / `TICK_MS)
// Button debounce time in microseconds.
`define DEBOUNCE_US       10000
`define DEBOUNCE_CYCLES   ((`CLK_HZ / 1000000) * `DEBOUNCE_US)
// Pressure band limits in millitorr (32-bit pressure word).
`define P_OVER_HI_MT      32'd1000000
`define P_OVER_LO_MT      32'd800000
`define P_ATM_LO_MT       32'd700000
`define P_ONE_TORR_MT     32'd1000
`define P_CENTI_TORR_MT   32'd10
// Lengths in ticks: 1 s period = 8 ticks, 2 s period = 16 ticks.
`define TICKS_1S          5'd8
`define TICKS_2S          5'd16
`define SHORT_FLASH_TICKS 5'd1
// Menu ring, orientation and baud choices.
`define MENU_PAGES        3'd7
`define ORIENT_STEPS      2'd3
`define BAUD_CHOICES      3'd5

`endif

//--- inc/gauge_panel_pkg.sv
package gauge_panel_pkg;

  typedef enum logic [1:0] {
    LAMP_OFF,
    LAMP_GREEN,
    LAMP_RED,
    LAMP_YELLOW
  } lamp_color_t;

  typedef enum logic [2:0] {
    BAUD_9600,
    BAUD_19200,
    BAUD_38400,
    BAUD_57600,
    BAUD_115200
  } baud_sel_t;

endpackage : gauge_panel_pkg

//--- inc/panel_tick_if.sv
interface panel_tick_if;
  logic       tick;
  logic [4:0] phase;

  modport source (output tick, output phase);
  modport sink   (input tick, input phase);
endinterface : panel_tick_if

//--- hdl/panel_tick_gen.sv
`include "gauge_panel_defs.svh"

module panel_tick_gen #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  panel_tick_if.source     tk
);
  initial begin
    if (TICK_CYCLES < 2) begin
      $error("TICK_CYCLES too small");
    end
  end

  logic [31:0] div;
  logic [31:0] next_div;
  logic [4:0]  phase;
  logic [4:0]  next_phase;
  logic        wrap;

  always_comb begin
    wrap       = (div == 32'(TICK_CYCLES - 1));
    next_div   = wrap ? 32'h0 : div + 32'h1;
    next_phase = wrap ? phase + 5'h1 : phase;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div   <= 32'h0;
      phase <= 5'h0;
    end else begin
      div   <= next_div;
      phase <= next_phase;
    end
  end

  assign tk.tick  = wrap;
  assign tk.phase = phase;
endmodule : panel_tick_gen

//--- hdl/button_conditioner.sv
`include "gauge_panel_defs.svh"

module button_conditioner #(
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_n_i,
  output logic      pressed_o
);
  initial begin
    if (DEBOUNCE_CYCLES < 1) begin
      $error("DEBOUNCE_CYCLES must be positive");
    end
  end

  logic [2:0]  sync;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        pressed;
  logic        next_pressed;
  logic        agreed;

  always_comb begin
    agreed       = (sync[1] == sync[2]);
    next_cnt     = cnt;
    next_pressed = pressed;
    if (!agreed || (!sync[2]) == pressed) begin
      next_cnt = 32'h0;
    end else if (cnt == 32'(DEBOUNCE_CYCLES - 1)) begin
      next_cnt     = 32'h0;
      next_pressed = !sync[2];
    end else begin
      next_cnt = cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync    <= 3'h7;
      cnt     <= 32'h0;
      pressed <= 1'b0;
    end else begin
      sync    <= {sync[1:0], pin_n_i};
      cnt     <= next_cnt;
      pressed <= next_pressed;
    end
  end

  assign pressed_o = pressed;
endmodule : button_conditioner

//--- hdl/gauge_panel.sv
`include "gauge_panel_defs.svh"

module gauge_panel #(
  parameter int TICK_CYCLES     = `TICK_CYCLES,
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
  parameter int ZERO_HOLD_TICKS = `ZERO_HOLD_TICKS,
  parameter int CHECK_TICKS     = `SELF_CHECK_TICKS
) (
  // Clock and reset.
  input  wire logic                        CLK_I,
  input  wire logic                        RST_N_I,
  // Push-button pin, low while pressed.
  input  wire logic                        BUTTON_N_I,
  input  wire logic                        HAS_DISPLAY_I,
  // Measured state, in millitorr.
  input  wire logic [31:0]                 PRESSURE_I,
  input  wire logic [31:0]                 SETPOINT_HI_I,
  input  wire logic [31:0]                 SETPOINT_LO_I,
  input  wire logic [31:0]                 ZERO_LIMIT_I,
  input  wire logic                        COMM_ERROR_I,
  input  wire logic                        CAL_MODE_I,
  input  wire logic                        ZERO_FORCE_I,
  // Touch-screen events, one-cycle pulses.
  input  wire logic                        MENU_NEXT_I,
  input  wire logic                        ORIENT_PRESS_I,
  input  wire logic                        BAUD_NEXT_I,
  input  wire logic                        SERIAL_SET_I,
  input  wire logic                        SERIAL_DIFF_I,
  input  wire logic                        MENU_ZERO_I,
  input  wire logic                        ZERO_CONFIRM_I,
  input  wire logic                        ZERO_CANCEL_I,
  // Lamps.
  output gauge_panel_pkg::lamp_color_t     STATUS_LAMP_O,
  output gauge_panel_pkg::lamp_color_t     CHAMBER_PRESSURE_LAMP_O,
  // Requests and settings.
  output logic                             ZERO_REQ_O,
  output logic                             ZERO_CONFIRM_WAIT_O,
  output logic                             SERIAL_DIFF_O,
  output logic                             BUS_OPTIONS_O,
  output logic                             READY_O,
  output logic                             SETPOINT_HI_O,
  output logic                             SETPOINT_LO_O,
  output logic [2:0]                       MENU_PAGE_O,
  output logic [1:0]                       ORIENT_O,
  output gauge_panel_pkg::baud_sel_t       BAUD_O
);
  initial begin
    if (ZERO_HOLD_TICKS < 1 || ZERO_HOLD_TICKS > 255 ||
        CHECK_TICKS < 3 || CHECK_TICKS > 255 ||
        DEBOUNCE_CYCLES + 3 >= 2 * TICK_CYCLES) begin
      $error("tick counts out of range");
    end
  end

  typedef enum logic [2:0] {
    ST_CHECK,
    ST_TOGGLE,
    ST_RUN,
    ST_HOLD,
    ST_ADJUST
  } panel_state_t;

  panel_tick_if tk ();

  panel_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .tk      (tk)
  );

  logic pressed;

  button_conditioner #(
    .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
  ) u_button (
    .clk_i     (CLK_I),
    .rst_n_i   (RST_N_I),
    .pin_n_i   (BUTTON_N_I),
    .pressed_o (pressed)
  );

  // Sequencer state.
  panel_state_t state;
  panel_state_t next_state;
  logic [7:0]   ticks;
  logic [7:0]   next_ticks;
  logic         zero_req;
  logic         next_zero_req;
  logic         diff;
  logic         next_diff;
  logic         held_at_start;
  logic         next_held_at_start;
  logic         confirm_wait;
  logic         next_confirm_wait;

  always_comb begin
    next_state         = state;
    next_ticks         = ticks;
    next_zero_req      = 1'b0;
    next_diff          = diff;
    next_held_at_start = held_at_start;
    if (SERIAL_SET_I) begin
      next_diff = SERIAL_DIFF_I;
    end
    case (state)
      ST_CHECK: begin
        // Give the debounced level two ticks to settle after reset.
        if (!pressed && ticks > 8'h1) begin
          next_held_at_start = 1'b0;
        end
        if (tk.tick) begin
          if (ticks == 8'(CHECK_TICKS - 1)) begin
            next_ticks = 8'h0;
            if (held_at_start && pressed && !HAS_DISPLAY_I) begin
              next_state = ST_TOGGLE;
              next_diff  = !diff;
            end else begin
              next_state = ST_RUN;
            end
          end else begin
            next_ticks = ticks + 8'h1;
          end
        end
      end
      ST_TOGGLE: begin
        if (!pressed) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_ticks = 8'h0;
        if (pressed) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!pressed) begin
          next_state = ST_RUN;
        end else if (tk.tick) begin
          if (ticks == 8'(ZERO_HOLD_TICKS - 1)) begin
            next_state    = ST_ADJUST;
            next_zero_req = 1'b1;
          end else begin
            next_ticks = ticks + 8'h1;
          end
        end
      end
      ST_ADJUST: begin
        if (!pressed) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_CHECK;
      end
    endcase
    if (MENU_ZERO_I && PRESSURE_I <= ZERO_LIMIT_I) begin
      next_zero_req = 1'b1;
    end
    if (confirm_wait && ZERO_CONFIRM_I) begin
      next_zero_req = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state         <= ST_CHECK;
      ticks         <= 8'h0;
      zero_req      <= 1'b0;
      diff          <= 1'b0;
      held_at_start <= 1'b1;
    end else begin
      state         <= next_state;
      ticks         <= next_ticks;
      zero_req      <= next_zero_req;
      diff          <= next_diff;
      held_at_start <= next_held_at_start;
    end
  end

  // Touch-screen settings.
  logic [2:0] page;
  logic [2:0] next_page;
  logic [1:0] orient;
  logic [1:0] next_orient;
  logic [2:0] baud;
  logic [2:0] next_baud;

  always_comb begin
    next_confirm_wait = confirm_wait;
    if (MENU_ZERO_I && PRESSURE_I > ZERO_LIMIT_I) begin
      next_confirm_wait = 1'b1;
    end else if (ZERO_CONFIRM_I || ZERO_CANCEL_I) begin
      next_confirm_wait = 1'b0;
    end
    next_page = page;
    if (MENU_NEXT_I) begin
      next_page = (page == `MENU_PAGES - 3'd1) ? 3'h0 : page + 3'h1;
    end
    next_orient = orient;
    if (ORIENT_PRESS_I) begin
      next_orient = orient + 2'h1;
    end
    next_baud = baud;
    if (BAUD_NEXT_I) begin
      next_baud = (baud == `BAUD_CHOICES - 3'd1) ? 3'h0 : baud + 3'h1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      confirm_wait <= 1'b0;
      page         <= 3'h0;
      orient       <= 2'h0;
      baud         <= 3'(gauge_panel_pkg::BAUD_19200);
    end else begin
      confirm_wait <= next_confirm_wait;
      page         <= next_page;
      orient       <= next_orient;
      baud         <= next_baud;
    end
  end

  // Lamp pattern selection; the shared tick phase keeps pairs aligned.
  gauge_panel_pkg::lamp_color_t next_status;
  gauge_panel_pkg::lamp_color_t next_chamber;
  gauge_panel_pkg::lamp_color_t status_lamp;
  gauge_panel_pkg::lamp_color_t chamber_lamp;
  logic        sp_hi;
  logic        sp_lo;
  logic        half_1s;
  logic        half_2s;
  logic        fast;
  logic [2:0]  duty;
  logic        duty_on;

  always_comb begin
    fast    = tk.phase[0];
    half_1s = tk.phase[2];
    half_2s = tk.phase[3];
    // Eighths of on-time grow with pressure across the band.
    duty    = 3'(PRESSURE_I / (`P_ATM_LO_MT / 32'd8));
    duty_on = ({2'b00, tk.phase[2:0]} <= {2'b00, duty});
    next_status  = gauge_panel_pkg::LAMP_GREEN;
    next_chamber = gauge_panel_pkg::LAMP_GREEN;
    if (state == ST_CHECK) begin
      next_status  = gauge_panel_pkg::LAMP_OFF;
      next_chamber = gauge_panel_pkg::LAMP_OFF;
    end else if (COMM_ERROR_I) begin
      next_status  = half_2s ? gauge_panel_pkg::LAMP_RED
                             : gauge_panel_pkg::LAMP_OFF;
      next_chamber = half_2s ? gauge_panel_pkg::LAMP_OFF
                             : gauge_panel_pkg::LAMP_RED;
    end else if (CAL_MODE_I) begin
      next_status  = half_1s ? gauge_panel_pkg::LAMP_GREEN
                             : gauge_panel_pkg::LAMP_OFF;
      next_chamber = next_status;
    end else if (state == ST_TOGGLE) begin
      next_status  = fast ? gauge_panel_pkg::LAMP_GREEN
                          : gauge_panel_pkg::LAMP_OFF;
      next_chamber = fast ? gauge_panel_pkg::LAMP_OFF
                          : gauge_panel_pkg::LAMP_GREEN;
    end else if (state == ST_ADJUST && ZERO_FORCE_I) begin
      next_status  = fast ? gauge_panel_pkg::LAMP_GREEN
                          : gauge_panel_pkg::LAMP_OFF;
      next_chamber = next_status;
    end else if (state == ST_ADJUST) begin
      next_chamber = fast ? gauge_panel_pkg::LAMP_GREEN
                          : gauge_panel_pkg::LAMP_OFF;
    end else if (PRESSURE_I > `P_OVER_HI_MT) begin
      next_chamber = half_1s ? gauge_panel_pkg::LAMP_YELLOW
                             : gauge_panel_pkg::LAMP_OFF;
    end else if (PRESSURE_I > `P_OVER_LO_MT) begin
      next_chamber = gauge_panel_pkg::LAMP_YELLOW;
    end else if (PRESSURE_I >= `P_ATM_LO_MT) begin
      next_chamber = gauge_panel_pkg::LAMP_GREEN;
    end else if (PRESSURE_I >= `P_ONE_TORR_MT) begin
      next_chamber = duty_on ? gauge_panel_pkg::LAMP_GREEN
                             : gauge_panel_pkg::LAMP_OFF;
    end else if (PRESSURE_I >= `P_CENTI_TORR_MT) begin
      next_chamber = (tk.phase[2:0] == 3'h0) ? gauge_panel_pkg::LAMP_GREEN
                                             : gauge_panel_pkg::LAMP_OFF;
    end else begin
      next_chamber = (tk.phase[3:0] == 4'h0) ? gauge_panel_pkg::LAMP_GREEN
                                             : gauge_panel_pkg::LAMP_OFF;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      status_lamp  <= gauge_panel_pkg::LAMP_OFF;
      chamber_lamp <= gauge_panel_pkg::LAMP_OFF;
      sp_hi        <= 1'b0;
      sp_lo        <= 1'b0;
    end else begin
      status_lamp  <= next_status;
      chamber_lamp <= next_chamber;
      sp_hi        <= (PRESSURE_I > SETPOINT_HI_I);
      sp_lo        <= (PRESSURE_I < SETPOINT_LO_I);
    end
  end

  assign STATUS_LAMP_O           = status_lamp;
  assign CHAMBER_PRESSURE_LAMP_O = chamber_lamp;
  assign ZERO_REQ_O              = zero_req;
  assign ZERO_CONFIRM_WAIT_O     = confirm_wait;
  assign SERIAL_DIFF_O           = diff;
  assign BUS_OPTIONS_O           = diff;
  assign READY_O                 = (state != ST_CHECK);
  assign SETPOINT_HI_O           = sp_hi;
  assign SETPOINT_LO_O           = sp_lo;
  assign MENU_PAGE_O             = page;
  assign ORIENT_O                = orient;
  assign BAUD_O                  = gauge_panel_pkg::baud_sel_t'(baud);
endmodule : gauge_panel

//--- verif/gauge_panel_asserts.sv
module gauge_panel_checker (
  // Clock and reset.
  input wire logic                         CLK_I,
  input wire logic                         RST_N_I,
  // Inputs watched.
  input wire logic [31:0]                  PRESSURE_I,
  input wire logic [31:0]                  SETPOINT_HI_I,
  input wire logic [31:0]                  SETPOINT_LO_I,
  input wire logic                         COMM_ERROR_I,
  input wire logic                         CAL_MODE_I,
  input wire logic                         MENU_NEXT_I,
  input wire logic                         ORIENT_PRESS_I,
  input wire logic                         BAUD_NEXT_I,
  // Outputs watched.
  input wire gauge_panel_pkg::lamp_color_t STATUS_LAMP_O,
  input wire gauge_panel_pkg::lamp_color_t CHAMBER_PRESSURE_LAMP_O,
  input wire logic                         ZERO_REQ_O,
  input wire logic                         SERIAL_DIFF_O,
  input wire logic                         BUS_OPTIONS_O,
  input wire logic                         READY_O,
  input wire logic                         SETPOINT_HI_O,
  input wire logic                         SETPOINT_LO_O,
  input wire logic [2:0]                   MENU_PAGE_O,
  input wire logic [1:0]                   ORIENT_O,
  input wire gauge_panel_pkg::baud_sel_t   BAUD_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  a_menu_ring: assert property (MENU_NEXT_I |=> MENU_PAGE_O ==
    (($past(MENU_PAGE_O) == 3'h6) ? 3'h0 : $past(MENU_PAGE_O) + 3'h1))
    else $error("menu page did not step round the ring");
  a_orient_step: assert property (ORIENT_PRESS_I |=>
    ORIENT_O == $past(ORIENT_O) + 2'h1)
    else $error("orientation did not advance a quarter turn");
  a_baud_step: assert property (BAUD_NEXT_I |=> BAUD_O ==
    (($past(BAUD_O) == gauge_panel_pkg::BAUD_115200) ? 3'h0
      : 3'($past(BAUD_O)) + 3'h1))
    else $error("baud choice did not step through five rates");
  a_bus_options: assert property (BUS_OPTIONS_O == SERIAL_DIFF_O)
    else $error("bus options shown without differential mode");
  a_dark_check: assert property (!READY_O |->
    STATUS_LAMP_O == gauge_panel_pkg::LAMP_OFF &&
    CHAMBER_PRESSURE_LAMP_O == gauge_panel_pkg::LAMP_OFF)
    else $error("lamp lit before self-check ended");
  a_comm_opposite: assert property (
    READY_O && $past(READY_O) && $past(COMM_ERROR_I) |->
    {STATUS_LAMP_O, CHAMBER_PRESSURE_LAMP_O} inside {4'h8, 4'h2})
    else $error("fault lamps not red in opposite phase");
  a_cal_sync: assert property (READY_O && $past(READY_O) &&
    $past(CAL_MODE_I) && !$past(COMM_ERROR_I) |->
    {STATUS_LAMP_O, CHAMBER_PRESSURE_LAMP_O} inside {4'h0, 4'h5})
    else $error("calibrate lamps not green in phase");
  a_high_setpoint: assert property ($past(RST_N_I) |->
    SETPOINT_HI_O == ($past(PRESSURE_I) > $past(SETPOINT_HI_I)))
    else $error("high setpoint does not follow its threshold");
  a_low_setpoint: assert property ($past(RST_N_I) |->
    SETPOINT_LO_O == ($past(PRESSURE_I) < $past(SETPOINT_LO_I)))
    else $error("low setpoint does not follow its threshold");

  c_menu_wrap: cover property (MENU_NEXT_I && MENU_PAGE_O == 3'h6);
  c_comm_seen: cover property (READY_O && COMM_ERROR_I);
  c_zero_req: cover property (ZERO_REQ_O);
endmodule : gauge_panel_checker

bind gauge_panel gauge_panel_checker gauge_panel_checker_i (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .PRESSURE_I(PRESSURE_I),
  .SETPOINT_HI_I(SETPOINT_HI_I), .SETPOINT_LO_I(SETPOINT_LO_I),
  .COMM_ERROR_I(COMM_ERROR_I), .CAL_MODE_I(CAL_MODE_I),
  .MENU_NEXT_I(MENU_NEXT_I), .ORIENT_PRESS_I(ORIENT_PRESS_I),
  .BAUD_NEXT_I(BAUD_NEXT_I), .STATUS_LAMP_O(STATUS_LAMP_O),
  .CHAMBER_PRESSURE_LAMP_O(CHAMBER_PRESSURE_LAMP_O),
  .ZERO_REQ_O(ZERO_REQ_O), .SERIAL_DIFF_O(SERIAL_DIFF_O),
  .BUS_OPTIONS_O(BUS_OPTIONS_O), .READY_O(READY_O),
  .SETPOINT_HI_O(SETPOINT_HI_O), .SETPOINT_LO_O(SETPOINT_LO_O),
  .MENU_PAGE_O(MENU_PAGE_O), .ORIENT_O(ORIENT_O), .BAUD_O(BAUD_O));

//--- verif/panel_operator.sv
module panel_operator (
  // Clock and the operator's intent.
  input  wire logic clk_i,
  input  wire logic hold_i,
  // Button pin, pulled up while released.
  output logic      button_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] bounce = 2'h0;
  logic       last   = 1'b0;

  initial button_n_o = 1'b1;
  // The contact chatters for three cycles after each press or release.
  always @(posedge clk_i) begin
    if (hold_i != last) begin
      bounce <= 2'h3;
    end else if (bounce != 2'h0) begin
      bounce <= bounce - 2'h1;
    end
    last       <= hold_i;
    button_n_o <= (bounce != 2'h0) ? bounce[0] : !hold_i;
  end
endmodule : panel_operator

//--- verif/gauge_panel_bench.sv
module gauge_panel_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef gauge_panel_pkg::lamp_color_t lamp_t;
  localparam lamp_t GRN = gauge_panel_pkg::LAMP_GREEN;
  logic        clk    = 1'b0;
  logic        rst_n  = 1'b0;
  logic        hold   = 1'b1;
  logic        diff   = 1'b0;
  logic        disp   = 1'b0;
  logic [31:0] pres   = 32'h0;
  logic [31:0] sp_hi  = 32'h0;
  logic [31:0] sp_lo  = 32'h0;
  logic [31:0] limit  = 32'h0;
  logic [2:0]  faults = 3'h0;
  logic [6:0]  ev     = 7'h0;
  logic        button_n, zreq, zwait, sdiff, busopt, ready, shi, slo;
  lamp_t       st, cp;
  logic [2:0]  page;
  logic [1:0]  orient;
  logic [1:0]  got;
  gauge_panel_pkg::baud_sel_t baud;
  int          mismatches = 0;
  int          n_tests    = 0;
  int          i, nz;
  logic [31:0] bp [6] = '{32'h16e360, 32'hdbba0, 32'hb98c0, 32'h55730,
                          32'h1f4, 32'h5};
  int          bw [6] = '{32, 32, 32, 32, 32, 64};
  int          bc [6] = '{16, 32, 32, 20, 4, 4};
  int          bq [6] = '{0, 0, 32, 20, 4, 4};

  initial begin
    forever #5 clk = !clk;
  end

  panel_operator panel_operator_i (.clk_i(clk), .hold_i(hold),
    .button_n_o(button_n));

  gauge_panel #(.TICK_CYCLES(4), .DEBOUNCE_CYCLES(2),
    .ZERO_HOLD_TICKS(6), .CHECK_TICKS(4)) gauge_panel_i (
    .CLK_I(clk), .RST_N_I(rst_n), .BUTTON_N_I(button_n),
    .HAS_DISPLAY_I(disp), .PRESSURE_I(pres), .SETPOINT_HI_I(sp_hi),
    .SETPOINT_LO_I(sp_lo), .ZERO_LIMIT_I(limit),
    .COMM_ERROR_I(faults[0]), .CAL_MODE_I(faults[1]),
    .ZERO_FORCE_I(faults[2]), .MENU_NEXT_I(ev[0]),
    .ORIENT_PRESS_I(ev[1]), .BAUD_NEXT_I(ev[2]), .SERIAL_SET_I(ev[3]),
    .SERIAL_DIFF_I(diff), .MENU_ZERO_I(ev[4]), .ZERO_CONFIRM_I(ev[5]),
    .ZERO_CANCEL_I(ev[6]), .STATUS_LAMP_O(st),
    .CHAMBER_PRESSURE_LAMP_O(cp), .ZERO_REQ_O(zreq),
    .ZERO_CONFIRM_WAIT_O(zwait), .SERIAL_DIFF_O(sdiff),
    .BUS_OPTIONS_O(busopt), .READY_O(ready), .SETPOINT_HI_O(shi),
    .SETPOINT_LO_O(slo), .MENU_PAGE_O(page), .ORIENT_O(orient),
    .BAUD_O(baud));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  task give_up;
    mismatches++;
    final_report();
  endtask : give_up

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Pulses one event input; the answer is caught on the taking edge.
  task evt(input int k);
    ev[k] = 1'b1;
    step(1);
    got   = {zreq, zwait};
    ev[k] = 1'b0;
    step(1);
  endtask : evt

  // Counts lamp colours and equal-lamp cycles over a window.
  task automatic measure(input int n, input lamp_t sc, input lamp_t cc,
                         input int es, input int ec, input int eq);
    int s = 0;
    int c = 0;
    int q = 0;
    repeat (n) begin
      s += (st === sc);
      c += (cp === cc);
      q += (st === cp);
      step(1);
    end
    chk(s, es);
    chk(c, ec);
    chk(q, eq);
  endtask : measure

  initial begin
    step(8);
    rst_n = 1'b1;
    for (i = 0; i < 300 && ready !== 1'b1; i++) step(1);
    if (ready !== 1'b1) give_up();
    step(2);
    chk(sdiff, 1);
    measure(8, GRN, GRN, 4, 4, 0);
    hold = 1'b0;
    step(20);
    chk(busopt, 1);
    evt(3);
    chk({sdiff, busopt}, 0);
    for (i = 1; i <= 8; i++) begin
      evt(0);
      chk(page, i % 7);
    end
    for (i = 1; i <= 5; i++) begin
      evt(1);
      chk(orient, i % 4);
    end
    for (i = 1; i <= 6; i++) begin
      evt(2);
      chk(baud, (i + 1) % 5);
    end
    pres  = 32'h1f4;
    sp_hi = 32'h190;
    sp_lo = 32'h258;
    step(2);
    chk({shi, slo}, 3);
    pres = 32'h2bc;
    step(2);
    chk({shi, slo}, 2);
    limit = 32'h64;
    pres  = 32'h32;
    evt(4);
    chk(got, 2);
    pres = 32'h1f4;
    evt(4);
    chk(got, 1);
    evt(5);
    chk(got, 2);
    evt(4);
    evt(6);
    chk(got, 0);
    for (i = 0; i < 6; i++) begin
      pres = bp[i];
      step(2);
      measure(bw[i], GRN, (i < 2) ? gauge_panel_pkg::LAMP_YELLOW : GRN,
              bw[i], bc[i], bq[i]);
    end
    pres   = 32'h16e360;
    faults = 3'h3;
    step(2);
    measure(64, gauge_panel_pkg::LAMP_RED, gauge_panel_pkg::LAMP_RED,
            32, 32, 0);
    faults = 3'h2;
    step(2);
    measure(32, GRN, GRN, 16, 16, 32);
    pres   = 32'h5;
    faults = 3'h4;
    hold   = 1'b1;
    nz     = 0;
    for (i = 0; i < 40; i++) begin
      if (i == 20) hold = 1'b0;
      nz += zreq;
      step(1);
    end
    chk(nz, 0);
    hold = 1'b1;
    for (i = 0; i < 100 && zreq !== 1'b1; i++) step(1);
    if (i == 100) give_up();
    chk(i >= 20, 1);
    step(2);
    measure(8, GRN, GRN, 4, 4, 8);
    faults = 3'h0;
    step(2);
    measure(8, GRN, GRN, 8, 4, 4);
    hold = 1'b0;
    step(20);
    // Power-up hold on a unit with a display must leave the type alone.
    disp  = 1'b1;
    hold  = 1'b1;
    rst_n = 1'b0;
    step(8);
    rst_n = 1'b1;
    for (i = 0; i < 300 && ready !== 1'b1; i++) step(1);
    if (ready !== 1'b1) give_up();
    step(2);
    chk({sdiff, busopt}, 0);
    final_report();
  end
endmodule : gauge_panel_bench
